// >>> dqs_capture_params.svh
// Constants for the strobe phase-shift and DDR capture block
`ifndef DQS_CAPTURE_PARAMS_SVH
`define DQS_CAPTURE_PARAMS_SVH

// =============================================================
// Geometry
`define NUM_EDGES      2
`define DQS_PER_EDGE   10
`define DQ_GROUP_W     8
`define LANE_IDX_W     4

// =============================================================
// Delay element and reference circuit
`define TAP_W          3
`define DLY_DEPTH      8
`define SETTLE_CNT_W   9
`define SETTLE_REF_CYC 9'h100
`define SETTLE_LAST    (`SETTLE_REF_CYC - 9'h001)
`define SETTLE_FIRST   9'h001

// =============================================================
// Data group width codes and lane owner masks
`define WM_CODE_X8     2'h0
`define WM_CODE_X16    2'h1
`define WM_CODE_X32    2'h2
`define OWN_MASK_X8    4'hf
`define OWN_MASK_X16   4'he
`define OWN_MASK_X32   4'hc

`endif

// >>> dqs_capture_pkg.sv
// Types shared by the strobe phase-shift and DDR capture block
`include "dqs_capture_params.svh"

package dqs_capture_pkg;

   typedef logic [`DQ_GROUP_W-1:0] dq_byte_t;
   typedef logic [`TAP_W-1:0]      tap_t;

   // Data group width per strobe
   typedef enum logic [1:0] {
      WM_X8  = `WM_CODE_X8,
      WM_X16 = `WM_CODE_X16,
      WM_X32 = `WM_CODE_X32
   } width_mode_t;

   // Reference circuit lock sequence, one-hot
   typedef enum logic [2:0] {
      LK_IDLE  = 3'h1,
      LK_TRACK = 3'h2,
      LK_LOCK  = 3'h4
   } lock_state_t;

   // Captured read pair of one lane
   typedef struct packed {
      dq_byte_t rise;
      dq_byte_t fall;
      logic     valid;
   } rd_word_t;

   // Write request of one lane
   typedef struct packed {
      dq_byte_t hi;
      dq_byte_t lo;
      logic     oe;
   } wr_word_t;

endpackage

// >>> dqs_phase_shift_ddr_capture.sv
// Strobe phase-shift reference, strobe delay, DDR capture and DDR output
//
// Summary of operation
// - While the output clock enable is high the output registers load new data each rising clock edge.
// - While the output clock enable is low the output registers keep their contents.
// - Each strobe passes its own delay element that centres it on its data window.
// - Delayed strobes form a local strobe bus whose edges qualify the core-clocked read capture outside bypass mode.
// - One reference circuit per edge sets the delay of all ten strobes on that edge.
// - All strobes of one edge share one shift; top and bottom shifts are independent.
// - Each reference circuit sets the phase within 256 reference clock cycles.
// - Each strobe qualifies a data group of eight, sixteen or thirty-two lines.
// - In bypass mode the read strobe is ignored and data is captured by the core clock.
// - The interface runs at clock rates up to 200 MHz, 400 Mbps per data line.
// - Read data is caught on alternate strobe edges and held so both bits align to one edge.
// - Write data from two rising-edge registers is muxed by clock, first bit high phase.
// - The output enable is registered on the falling clock edge before driving the pins.
`timescale 1ns/10ps

module dqs_phase_shift_ddr_capture
   import dqs_capture_pkg::*;
(
   // Core clock and reset
   input  wire logic                                        clk,
   input  wire logic                                        srst,
   // Reference clock for the phase-shift circuits
   input  wire logic                                        ref_clk,
   // Configuration
   input  wire width_mode_t                                 width_mode,
   input  wire logic                                        bypass_dqs,
   input  wire tap_t        [`NUM_EDGES-1:0]                 phase_sel,
   // Write side
   input  wire logic                                        oce,
   input  wire wr_word_t    [`NUM_EDGES-1:0][`DQS_PER_EDGE-1:0] wr,
   // Read side
   output rd_word_t         [`NUM_EDGES-1:0][`DQS_PER_EDGE-1:0] rd,
   output logic             [`NUM_EDGES-1:0]                 locked,
   // Memory pins
   input  wire logic        [`NUM_EDGES-1:0][`DQS_PER_EDGE-1:0] dqs_i,
   input  wire dq_byte_t    [`NUM_EDGES-1:0][`DQS_PER_EDGE-1:0] dq_i,
   output dq_byte_t         [`NUM_EDGES-1:0][`DQS_PER_EDGE-1:0] dq_o,
   output dq_byte_t         [`NUM_EDGES-1:0][`DQS_PER_EDGE-1:0] dq_oe
);

   // =============================================================
   // Functions

   // Strobe that qualifies a lane for the selected group width
   function automatic logic [`LANE_IDX_W-1:0] lane_owner(
      input logic [`LANE_IDX_W-1:0] lane,
      input width_mode_t            mode
   );
      logic [`LANE_IDX_W-1:0] mask;
      mask = `OWN_MASK_X8;
      case (mode)
         WM_X16:  mask = `OWN_MASK_X16;
         WM_X32:  mask = `OWN_MASK_X32;
         default: mask = `OWN_MASK_X8;
      endcase
      return lane & mask;
   endfunction

   // =============================================================
   // Reset into the reference clock domain

   logic ref_rst_m_r;
   logic ref_rst_r;

   // Two-flop reset crossing
   always_ff @(posedge ref_clk) begin
      ref_rst_m_r <= srst;
      ref_rst_r   <= ref_rst_m_r;
   end

   // Bypass flag sync (treated as a slow configuration level)
   logic bypass_r;
   logic cyc_odd_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         bypass_r <= 1'b0;
      end else begin
         bypass_r <= bypass_dqs;
      end
   end

   // Alternating cycle marker for bypass capture
   always_ff @(posedge clk) begin
      if (srst) begin
         cyc_odd_r <= 1'b0;
      end else begin
         cyc_odd_r <= ~cyc_odd_r;
      end
   end

   genvar e;
   genvar l;

   // =============================================================
   // One reference circuit and one strobe group per device edge

   for (e = 0; e < `NUM_EDGES; e++) begin : g_edge

      // ----- Reference clock domain -----
      tap_t                    ph_m_r;
      tap_t                    ph_s_r;
      tap_t                    target_r;
      tap_t                    tap_ref_r;
      lock_state_t             lk_state_r;
      logic [`SETTLE_CNT_W-1:0] settle_cnt_r;
      logic                    lock_ref_r;

      // Phase request crossing into the reference domain
      always_ff @(posedge ref_clk) begin
         ph_m_r <= phase_sel[e];
         ph_s_r <= ph_m_r;
      end

      always_ff @(posedge ref_clk) begin
         if (ref_rst_r) begin
            lk_state_r   <= LK_IDLE;
            settle_cnt_r <= '0;
            target_r     <= '0;
            tap_ref_r    <= '0;
            lock_ref_r   <= 1'b0;
         end else begin
            case (lk_state_r)
               LK_IDLE: begin
                  target_r     <= ph_s_r;
                  settle_cnt_r <= `SETTLE_FIRST;
                  lock_ref_r   <= 1'b0;
                  lk_state_r   <= LK_TRACK;
               end
               LK_TRACK: begin
                  if (ph_s_r != target_r) begin
                     lk_state_r <= LK_IDLE;
                  end else if (settle_cnt_r == `SETTLE_LAST) begin
                     tap_ref_r  <= target_r;
                     lock_ref_r <= 1'b1;
                     lk_state_r <= LK_LOCK;
                  end else begin
                     settle_cnt_r <= settle_cnt_r + `SETTLE_FIRST;
                  end
               end
               LK_LOCK: begin
                  // Drop lock before a new shift is applied
                  if (ph_s_r != target_r) begin
                     lock_ref_r <= 1'b0;
                     lk_state_r <= LK_IDLE;
                  end
               end
               default: begin
                  lk_state_r <= LK_IDLE;
               end
            endcase
         end
      end

      // ----- Core clock domain -----
      logic lk_m_r;
      logic lk_s_r;
      logic lk_d_r;
      tap_t tap_r;
      logic applied_r;

      // Lock level crossing into the core domain
      always_ff @(posedge clk) begin
         if (srst) begin
            lk_m_r <= 1'b0;
            lk_s_r <= 1'b0;
            lk_d_r <= 1'b0;
         end else begin
            lk_m_r <= lock_ref_r;
            lk_s_r <= lk_m_r;
            lk_d_r <= lk_s_r;
         end
      end

      // one shared shift taken while the reference holds it stable
      always_ff @(posedge clk) begin
         if (srst) begin
            tap_r     <= '0;
            applied_r <= 1'b0;
         end else begin
            if (lk_s_r && !lk_d_r) begin
               tap_r <= tap_ref_r;
            end
            applied_r <= lk_s_r && lk_d_r;
         end
      end

      assign locked[e] = applied_r;

      // Local strobe bus of this edge
      logic [`DQS_PER_EDGE-1:0] sbus;

      for (l = 0; l < `DQS_PER_EDGE; l++) begin : g_lane

         logic                  s_m_r;
         logic                  s_s_r;
         logic [`DLY_DEPTH-1:0] dly_r;
         dq_byte_t              d_m_r;
         dq_byte_t              d_s_r;

         // Pin synchronisers for strobe and data
         always_ff @(posedge clk) begin
            if (srst) begin
               s_m_r <= 1'b0;
               s_s_r <= 1'b0;
               d_m_r <= '0;
               d_s_r <= '0;
            end else begin
               s_m_r <= dqs_i[e][l];
               s_s_r <= s_m_r;
               d_m_r <= dq_i[e][l];
               d_s_r <= d_m_r;
            end
         end

         always_ff @(posedge clk) begin
            if (srst) begin
               dly_r <= '0;
            end else begin
               dly_r <= {dly_r[`DLY_DEPTH-2:0], s_s_r};
            end
         end

         // delayed strobe drives the local strobe bus
         assign sbus[l] = dly_r[tap_r];

         // ----- Read capture -----
         logic     own_s;
         logic     own_d_r;
         logic     s_rise;
         logic     s_fall;
         dq_byte_t hold_r;

         assign own_s  = sbus[lane_owner(`LANE_IDX_W'(l), width_mode)];
         assign s_rise = own_s & ~own_d_r;
         assign s_fall = ~own_s & own_d_r;

         always_ff @(posedge clk) begin
            if (srst) begin
               own_d_r <= 1'b0;
            end else begin
               own_d_r <= own_s;
            end
         end

         // hold the first bit until the second arrives
         always_ff @(posedge clk) begin
            if (srst) begin
               hold_r <= '0;
            end else if (bypass_r ? !cyc_odd_r : s_rise) begin
               hold_r <= d_s_r;
            end
         end

         // bypass pairs core-clock samples; strobe-mode valid only once locked
         always_ff @(posedge clk) begin
            if (srst) begin
               rd[e][l] <= '0;
            end else if (bypass_r) begin
               rd[e][l].rise  <= cyc_odd_r ? hold_r : rd[e][l].rise;
               rd[e][l].fall  <= cyc_odd_r ? d_s_r : rd[e][l].fall;
               rd[e][l].valid <= cyc_odd_r;
            end else begin
               rd[e][l].rise  <= s_fall ? hold_r : rd[e][l].rise;
               rd[e][l].fall  <= s_fall ? d_s_r : rd[e][l].fall;
               rd[e][l].valid <= s_fall && applied_r;
            end
         end

         // ----- Write path -----
         dq_byte_t hi_r;
         dq_byte_t lo_r;
         logic     oe_pos_r;
         logic     oe_neg_r;

         // load while enabled; hold while disabled
         always_ff @(posedge clk) begin
            if (srst) begin
               hi_r     <= '0;
               lo_r     <= '0;
               oe_pos_r <= 1'b0;
            end else if (oce) begin
               hi_r     <= wr[e][l].hi;
               lo_r     <= wr[e][l].lo;
               oe_pos_r <= wr[e][l].oe;
            end
         end

         // output enable retimed on the falling edge
         always_ff @(negedge clk) begin
            if (srst) begin
               oe_neg_r <= 1'b0;
            end else begin
               oe_neg_r <= oe_pos_r;
            end
         end

         // clock selects first bit high, second bit low
         assign dq_o[e][l]  = clk ? hi_r : lo_r;
         assign dq_oe[e][l] = {`DQ_GROUP_W{oe_neg_r}};
      end
   end

endmodule

// >>> dqs_capture_chk.sv
// Assertion checker for the strobe capture block
`timescale 1ns/10ps
module dqs_capture_chk
   import dqs_capture_pkg::*;
(
   // Clock, reset, controls
   input wire logic                clk,
   input wire logic                srst,
   input wire width_mode_t         width_mode,
   input wire logic                bypass_dqs,
   input wire tap_t     [1:0]      phase_sel,
   input wire logic                oce,
   input wire wr_word_t [1:0][9:0] wr,
   // Results
   input wire rd_word_t [1:0][9:0] rd,
   input wire logic     [1:0]      locked,
   input wire dq_byte_t [1:0][9:0] dq_o,
   input wire dq_byte_t [1:0][9:0] dq_oe
);
   logic [15:0] wait_r;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ====================
   // Unlocked cycles since reset or phase change
   always_ff @(posedge clk) begin
      if (srst || $changed(phase_sel)) begin
         wait_r <= 16'h0000;
      end else if (locked != 2'h3) begin
         wait_r <= wait_r + 16'h0001;
      end
   end
   a_oce_load: assert property (oce |=> dq_o[1][9] == $past(wr[1][9].lo))
      else $error("no output load");
   a_oce_hold: assert property (!oce |=> $stable(dq_o) && $stable(dq_oe))
      else $error("output changed while held");
   a_oe_retime: assert property (oce |=> dq_oe[0][3] == {8{$past(wr[0][3].oe)}})
      else $error("enable not retimed");
   a_lock_bound: assert property (wait_r < 16'd8600)
      else $error("lock too slow");
   a_lock_early: assert property ($rose(locked[0]) |-> wait_r > 16'd8000)
      else $error("lock too early");
   a_valid_lock: assert property (rd[1][2].valid && !$past(bypass_dqs) && !$past(bypass_dqs, 2)
      |-> $past(locked[1])) else $error("pair before lock");
   a_valid_pulse: assert property (rd[0][0].valid && !bypass_dqs |=> !rd[0][0].valid)
      else $error("pair longer than a cycle");
   a_x32_share: assert property (width_mode == WM_X32 && !bypass_dqs
      |-> rd[0][1].valid == rd[0][0].valid) else $error("wide group split");
   a_bypass_rate: assert property (bypass_dqs [*4] |-> rd[1][5].valid != $past(rd[1][5].valid))
      else $error("bypass cadence wrong");
endmodule

bind dqs_phase_shift_ddr_capture dqs_capture_chk dqs_capture_chk_inst (.clk(clk), .srst(srst),
   .width_mode(width_mode), .bypass_dqs(bypass_dqs), .phase_sel(phase_sel), .oce(oce), .wr(wr),
   .rd(rd), .locked(locked), .dq_o(dq_o), .dq_oe(dq_oe));

// >>> mem_model.sv
// Behavioural memory returning strobe framed read data
`timescale 1ns/10ps
module mem_model
   import dqs_capture_pkg::*;
(
   // Clock and request
   input  wire logic          clk,
   input  wire logic          go,
   input  wire dq_byte_t      d_rise,
   input  wire dq_byte_t      d_fall,
   // Memory pins
   output logic [1:0][9:0]    dqs_i,
   output dq_byte_t [1:0][9:0] dq_i
);
   int       ph = 99;
   dq_byte_t cur = 8'h00;
   // ====================
   // strobe frames pair
   always @(posedge clk) begin
      if (go) ph = 0;
      else if (ph < 99) ph = ph + 1;
      cur = ph < 13 ? d_rise : ph < 27 ? d_fall : ~cur; // Released lines toggle
      dqs_i <= {20{ph > 0 && ph < 13}};
      dq_i <= {20{cur}};
   end
endmodule

// >>> dqs_phase_shift_ddr_capture_bench.sv
// Self-checking bench for the strobe capture block
`timescale 1ns/10ps
module dqs_phase_shift_ddr_capture_bench;
   import dqs_capture_pkg::*;
   logic                clk = 0, srst = 1, ref_clk = 0, bypass_dqs = 0, oce = 0, go = 0;
   width_mode_t         width_mode = WM_X8;
   tap_t     [1:0]      phase_sel = {3'h5, 3'h2};
   wr_word_t [1:0][9:0] wr = '0;
   rd_word_t [1:0][9:0] rd;
   logic     [1:0]      locked;
   logic     [1:0][9:0] dqs_i;
   dq_byte_t [1:0][9:0] dq_i, dq_o, dq_oe;
   dq_byte_t            d_r = 8'h00, d_f = 8'h00;
   int                  mismatches = 0, compares = 0, n;
   // Rows: oce, hi, lo, oe, expected hi, lo, oe
   logic [43:0] rows [4] = '{44'h1a53c1a53c1, 44'h0ff000a53c1, 44'h15ac305ac30, 44'h100ff100ff1};
   // ====================
   // 200 MHz core clock, 6.25 MHz reference clock
   initial forever #2.5 clk = ~clk;
   initial begin
      #37;
      forever #80 ref_clk = ~ref_clk;
   end
   dqs_phase_shift_ddr_capture dqs_phase_shift_ddr_capture_inst (.clk(clk), .srst(srst),
      .ref_clk(ref_clk), .width_mode(width_mode), .bypass_dqs(bypass_dqs),
      .phase_sel(phase_sel), .oce(oce), .wr(wr), .rd(rd), .locked(locked), .dqs_i(dqs_i),
      .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
   mem_model mem_model_inst (.clk(clk), .go(go), .d_rise(d_r), .d_fall(d_f), .dqs_i(dqs_i),
      .dq_i(dq_i));
   // Verdict and end of run
   task automatic summarize();
      if (mismatches == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Compare one value
   task automatic chk(string what, logic [159:0] exp, logic [159:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Field of all lanes of one edge
   function automatic logic [159:0] pick(int e, int f);
      logic [159:0] v;
      v = '0;
      for (int i = 0; i < 10; i++)
         v[i*8 +: 8] = f == 0 ? rd[e][i].rise : f == 1 ? rd[e][i].fall : 8'(rd[e][i].valid);
      return v;
   endfunction
   // Bounded wait; cycles taken in n
   task automatic wait_until(int sel, int lim, bit want);
      bit hit;
      n = 0;
      hit = 0;
      while (!hit && n < lim) begin
         @(posedge clk);
         #1;
         n++;
         hit = sel == 0 ? locked === 2'h3 : sel == 1 ? locked[0] === 1'b0 :
               rd[sel-2][0].valid === 1'b1;
      end
      chk("wait", want, hit);
      if (want && !hit) summarize();
   endtask
   // One read frame, then pair checks per edge
   task automatic burst(dq_byte_t a, dq_byte_t b, int skew, bit ok);
      @(posedge clk);
      d_r <= a;
      d_f <= b;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wait_until(2, 40, ok);
      for (int e = 0; e < 2 && ok; e++) begin
         if (e == 1) begin
            wait_until(3, 10, 1'b1);
            chk("skew", skew, n);
         end
         chk("rise", {10{a}}, pick(e, 0));
         chk("fall", {10{b}}, pick(e, 1));
         chk("valid", {10{8'h01}}, pick(e, 2));
      end
   endtask
   // Main sequence
   initial begin
      repeat (100) @(posedge clk);
      #1;
      chk("reset_rd", '0, pick(0, 2) | pick(1, 0));
      chk("reset_out", '0, {dq_o[0], dq_oe[1]});
      chk("reset_lock", '0, locked);
      @(posedge clk);
      srst <= 1'b0;
      foreach (rows[i]) begin
         @(posedge clk);
         oce <= rows[i][40];
         wr <= {20{rows[i][39:24], rows[i][20]}};
         @(posedge clk);
         #1;
         chk("dq_hi", {20{rows[i][19:12]}}, dq_o);
         chk("oe_early", {20{{8{i > 0 && rows[i-1][0]}}}}, dq_oe);
         @(negedge clk);
         #1;
         chk("dq_lo", {20{rows[i][11:4]}}, dq_o);
         chk("oe", {20{{8{rows[i][0]}}}}, dq_oe);
      end
      burst(8'h11, 8'h22, 0, 1'b0);
      wait_until(0, 9000, 1'b1);
      for (int m = 0; m < 3; m++) begin
         width_mode <= width_mode_t'(m);
         burst(8'h5a + 8'(m), 8'ha5 - 8'(m), 3, 1'b1);
      end
      bypass_dqs <= 1'b1;
      wait_until(2, 6, 1'b1);
      repeat (8) @(posedge clk);
      bypass_dqs <= 1'b0;
      repeat (4) @(posedge clk);
      phase_sel[0] <= 3'h0;
      wait_until(1, 300, 1'b1);
      chk("lock_other", 1'b1, locked[1]);
      wait_until(0, 9000, 1'b1);
      burst(8'he7, 8'h18, 5, 1'b1);
      summarize();
   end
endmodule
